// file: hw/nfctm_pkg.sv
// package of constants for the reader protocol timer unit
// What this block does
// - clear command stops all but wake-up timer and the mode 1 no-response timer
// - transmit end starts mask and no-response timers
// - mask timer running holds receive window low
// - mask timer drives squelch, raises no interrupt
// - peer field on starts mask timer in peer mode
// - low-power target: mask start command steps 512/fc, then watch
// - step bit picks 64/fc or 4096/fc
// - mode 0: expiry interrupts, reply start stops
// - mode 1: always interrupts, ignores clear
// - start command restarts; ignored in peer mode
// - peer mode: expiry before peer field interrupts
// - general timer triggered by selected event, interrupts
// - general start command starts or restarts it
// - wake-up start refused in wake-up mode
// - carrier timers run only with stable oscillator
// - oscillator stable sets status and interrupt flag
// - eight-bit successive approximation result held
// - absolute mode spans 00h to FFh codes
// - relative mode only for phase measurement
package nfctm_pkg;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_MRT     = 8'h04;
	localparam logic [7:0]  OFS_NRT     = 8'h08;
	localparam logic [7:0]  OFS_GPT     = 8'h0c;
	localparam logic [7:0]  OFS_WUT     = 8'h10;
	localparam logic [7:0]  OFS_CMD     = 8'h14;
	localparam logic [7:0]  OFS_FLAGS   = 8'h18;
	localparam logic [7:0]  OFS_STATUS  = 8'h1c;
	localparam logic [7:0]  OFS_ADC     = 8'h20;

	// control register fields
	localparam int          CTL_OSC_EN  = 0;
	localparam int          CTL_NRT_STEP = 1;
	localparam int          CTL_NRT_EMV = 2;
	localparam int          CTL_GPT_TRIG = 3;
	localparam int          CTL_P2P     = 5;
	localparam int          CTL_LPTGT   = 6;
	localparam int          CTL_WUMODE  = 7;
	localparam int          CTL_SQ_EN   = 8;
	localparam int          CTL_WIDTH   = 9;
	localparam logic [8:0]  CTL_RESET   = 9'h000;

	// command register bits
	localparam int          CMD_CLEAR   = 0;
	localparam int          CMD_MRT     = 1;
	localparam int          CMD_NRT     = 2;
	localparam int          CMD_GPT     = 3;
	localparam int          CMD_WUT     = 4;
	localparam int          CMD_ADC     = 5;

	// flag register bits
	localparam int          FLG_NRE     = 0;
	localparam int          FLG_GPT     = 1;
	localparam int          FLG_OSC     = 2;
	localparam int          FLG_TXE     = 3;
	localparam int          FLG_WT      = 4;
	localparam int          FLG_WIDTH   = 5;

	// general timer trigger selections
	localparam logic [1:0]  TRIG_NONE   = 2'h0;
	localparam logic [1:0]  TRIG_RXSOF  = 2'h1;
	localparam logic [1:0]  TRIG_RXEOF  = 2'h2;
	localparam logic [1:0]  TRIG_FOFF   = 2'h3;

	// tick steps in carrier periods
	localparam int          STEP_MRT    = 64;
	localparam int          STEP_MRT_LP = 512;
	localparam int          STEP_NRT_LO = 64;
	localparam int          STEP_NRT_HI = 4096;
	localparam int          STEP_GPT    = 64;
	localparam int          PRE_W       = 12;

	// converter timing
	localparam int          ADC_SETTLE_NS = 500;
	localparam int          CLK_NS        = 25;
	localparam int          ADC_SETTLE    = (ADC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0]  ADC_MID       = 8'h80;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// file: hw/nfctm_top.sv
// reader protocol timers, oscillator status and converter control
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module nfctm_top
	import nfctm_pkg::*;
#(
	parameter int MRT_W = 8,
	parameter int NRT_W = 16,
	parameter int GPT_W = 16,
	parameter int WUT_W = 8
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        fc_en,
	input  wire logic        tx_end,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        reply_busy,
	input  wire logic        peer_field_on,
	input  wire logic        peer_field_off,
	input  wire logic        osc_stable_pin,
	input  wire logic        rc_clk_pin,
	input  wire logic        adc_comp_pin,
	input  wire logic        phase_meas,
	output logic             osc_enable,
	output logic             rc_osc_enable,
	output logic             rx_window,
	output logic             squelch_on,
	output logic             rx_watch,
	output logic [7:0]       adc_dac,
	output logic             adc_relative
);
	logic                 awdone_q, wdone_q;
	logic [7:0]           awaddr_q;
	logic [31:0]          wdata_q;
	logic [3:0]           wstrb_q;
	logic                 bvalid_q, rvalid_q;
	logic [31:0]          rdata_q;
	logic [1:0]           rresp_q, bresp_q;
	logic                 wr_go, wr_ok;
	logic [CTL_WIDTH-1:0] ctrl_q;
	logic [MRT_W-1:0]     mrt_val_q;
	logic [NRT_W-1:0]     nrt_val_q;
	logic [GPT_W-1:0]     gpt_val_q;
	logic [WUT_W-1:0]     wut_val_q;
	logic [FLG_WIDTH-1:0] flags_q, flag_set, flag_clr;
	logic                 cmd_clear, cmd_mrt, cmd_nrt, cmd_gpt, cmd_wut, cmd_adc;
	logic [2:0]           osc_sync_q, rc_sync_q;
	logic                 osc_ok, rc_tick;
	logic                 p2p, emv;
	logic                 mrt_run_q, mrt_lp_q, nrt_run_q, gpt_run_q, wut_run_q;
	logic [MRT_W-1:0]     mrt_cnt_q;
	logic [NRT_W-1:0]     nrt_cnt_q;
	logic [GPT_W-1:0]     gpt_cnt_q;
	logic [WUT_W-1:0]     wut_cnt_q;
	logic [PRE_W-1:0]     mrt_pre_q, nrt_pre_q, gpt_pre_q;
	logic [PRE_W-1:0]     mrt_last, nrt_last;
	logic                 fc_go, mrt_tick, nrt_tick, gpt_tick;
	logic                 mrt_exp, nrt_exp, gpt_exp, wut_exp;
	logic                 mrt_start, nrt_start, gpt_start, gpt_trig;
	logic                 nrt_stop, force_low_q, watch_q;
	logic [1:0]           adc_sync_q;
	logic                 adc_busy_q, adc_rel_q;
	logic [2:0]           adc_bit_q;
	logic [7:0]           adc_try_q, adc_res_q;
	logic [$clog2(ADC_SETTLE+1)-1:0] adc_wait_q;

	// bus slave: address and data accepted in either order, response after both
	assign s_axi_awready = !awdone_q && !bvalid_q;
	assign s_axi_wready  = !wdone_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign wr_go = awdone_q && wdone_q && !bvalid_q;
	assign wr_ok = awaddr_q <= OFS_ADC && awaddr_q[1:0] == 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awdone_q <= 1'b0;
			wdone_q  <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awdone_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdone_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				awdone_q <= 1'b0;
				wdone_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// configuration writes; software keeps them to idle timers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= CTL_RESET;
			mrt_val_q <= '0;
			nrt_val_q <= '0;
			gpt_val_q <= '0;
			wut_val_q <= '0;
		end else if (wr_go && wstrb_q[0]) begin
			unique case (awaddr_q)
				OFS_CTRL: begin
					ctrl_q[7:0] <= wdata_q[7:0];
					if (wstrb_q[1]) ctrl_q[8] <= wdata_q[8];
				end
				OFS_MRT:  mrt_val_q <= wdata_q[MRT_W-1:0];
				OFS_NRT:  nrt_val_q <= wdata_q[NRT_W-1:0];
				OFS_GPT:  gpt_val_q <= wdata_q[GPT_W-1:0];
				OFS_WUT:  wut_val_q <= wdata_q[WUT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// command strobes, one cycle each
	always_comb begin
		logic hit;
		hit       = wr_go && wstrb_q[0] && awaddr_q == OFS_CMD;
		cmd_clear = hit && wdata_q[CMD_CLEAR];
		cmd_mrt   = hit && wdata_q[CMD_MRT];
		cmd_nrt   = hit && wdata_q[CMD_NRT];
		cmd_gpt   = hit && wdata_q[CMD_GPT];
		cmd_wut   = hit && wdata_q[CMD_WUT];
		cmd_adc   = hit && wdata_q[CMD_ADC];
		flag_clr  = (wr_go && wstrb_q[0] && awaddr_q == OFS_FLAGS) ?
			wdata_q[FLG_WIDTH-1:0] : '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CTRL:   rdata_q <= 32'(ctrl_q);
				OFS_MRT:    rdata_q <= 32'(mrt_val_q);
				OFS_NRT:    rdata_q <= 32'(nrt_val_q);
				OFS_GPT:    rdata_q <= 32'(gpt_val_q);
				OFS_WUT:    rdata_q <= 32'(wut_val_q);
				OFS_CMD:    rdata_q <= 32'h0000_0000;
				OFS_FLAGS:  rdata_q <= 32'(flags_q);
				OFS_STATUS: rdata_q <= 32'({watch_q, rx_window, osc_ok, adc_busy_q,
					wut_run_q, gpt_run_q, nrt_run_q, mrt_run_q});
				OFS_ADC:    rdata_q <= 32'({adc_rel_q, adc_res_q});
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// pin synchronisers; stage 0 feeds stage 1 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_sync_q <= 3'h0;
			rc_sync_q  <= 3'h0;
			adc_sync_q <= 2'h0;
		end else begin
			osc_sync_q <= {osc_sync_q[1:0], osc_stable_pin};
			rc_sync_q  <= {rc_sync_q[1:0], rc_clk_pin};
			adc_sync_q <= {adc_sync_q[0], adc_comp_pin};
		end
	end
	assign osc_ok  = osc_sync_q[1] && ctrl_q[CTL_OSC_EN];
	assign rc_tick = rc_sync_q[1] && !rc_sync_q[2];
	assign osc_enable    = ctrl_q[CTL_OSC_EN];
	assign rc_osc_enable = wut_run_q;

	assign p2p   = ctrl_q[CTL_P2P];
	assign emv   = ctrl_q[CTL_NRT_EMV];
	assign fc_go = fc_en && osc_ok;

	// mask receive timer
	assign mrt_last  = mrt_lp_q ? PRE_W'(STEP_MRT_LP - 1) : PRE_W'(STEP_MRT - 1);
	assign mrt_tick  = mrt_run_q && fc_go && mrt_pre_q == mrt_last;
	assign mrt_exp   = mrt_tick && mrt_cnt_q <= MRT_W'(1);
	assign mrt_start = tx_end || (p2p && peer_field_on) || cmd_mrt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mrt_run_q <= 1'b0;
			mrt_lp_q  <= 1'b0;
			mrt_cnt_q <= '0;
			mrt_pre_q <= '0;
		end else if (mrt_start) begin
			mrt_run_q <= 1'b1;
			mrt_lp_q  <= cmd_mrt && ctrl_q[CTL_LPTGT];
			mrt_cnt_q <= mrt_val_q;
			mrt_pre_q <= '0;
		end else if (cmd_clear || mrt_exp) begin
			mrt_run_q <= 1'b0;
		end else if (mrt_tick) begin
			mrt_pre_q <= '0;
			mrt_cnt_q <= mrt_cnt_q - MRT_W'(1);
		end else if (mrt_run_q && fc_go) begin
			mrt_pre_q <= mrt_pre_q + PRE_W'(1);
		end
	end

	// after a low-power target mask window, watch for the initiator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watch_q <= 1'b0;
		end else if (mrt_start || cmd_clear) begin
			watch_q <= 1'b0;
		end else if (mrt_exp && mrt_lp_q) begin
			watch_q <= 1'b1;
		end
	end
	assign rx_watch = watch_q;

	// no-response timer
	assign nrt_last  = ctrl_q[CTL_NRT_STEP] ? PRE_W'(STEP_NRT_HI - 1) :
		PRE_W'(STEP_NRT_LO - 1);
	assign nrt_tick  = nrt_run_q && fc_go && nrt_pre_q == nrt_last;
	assign nrt_exp   = nrt_tick && nrt_cnt_q <= NRT_W'(1);
	assign nrt_start = tx_end || (cmd_nrt && !p2p);
	assign nrt_stop  = (cmd_clear && !emv) || (rx_sof && !emv) || (p2p && peer_field_on);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nrt_run_q <= 1'b0;
			nrt_cnt_q <= '0;
			nrt_pre_q <= '0;
		end else if (nrt_start) begin
			nrt_run_q <= 1'b1;
			nrt_cnt_q <= nrt_val_q;
			nrt_pre_q <= '0;
		end else if (nrt_stop || nrt_exp) begin
			nrt_run_q <= 1'b0;
		end else if (nrt_tick) begin
			nrt_pre_q <= '0;
			nrt_cnt_q <= nrt_cnt_q - NRT_W'(1);
		end else if (nrt_run_q && fc_go) begin
			nrt_pre_q <= nrt_pre_q + PRE_W'(1);
		end
	end

	// expiry closes the receive window unless a reply is under way in mode 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_low_q <= 1'b0;
		end else if (nrt_exp && !nrt_stop && !nrt_start && !(emv && reply_busy)) begin
			force_low_q <= 1'b1;
		end else if (tx_end || mrt_start) begin
			force_low_q <= 1'b0;
		end
	end
	assign rx_window  = !mrt_run_q && !force_low_q;
	assign squelch_on = mrt_run_q && ctrl_q[CTL_SQ_EN];

	// general purpose timer
	always_comb begin
		unique case (ctrl_q[CTL_GPT_TRIG +: 2])
			TRIG_RXSOF: gpt_trig = rx_sof;
			TRIG_RXEOF: gpt_trig = rx_eof;
			TRIG_FOFF:  gpt_trig = p2p && peer_field_off;
			TRIG_NONE:  gpt_trig = 1'b0;
		endcase
	end
	assign gpt_start = gpt_trig || cmd_gpt;
	assign gpt_tick  = gpt_run_q && fc_go && gpt_pre_q == PRE_W'(STEP_GPT - 1);
	assign gpt_exp   = gpt_tick && gpt_cnt_q <= GPT_W'(1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gpt_run_q <= 1'b0;
			gpt_cnt_q <= '0;
			gpt_pre_q <= '0;
		end else if (gpt_start) begin
			gpt_run_q <= 1'b1;
			gpt_cnt_q <= gpt_val_q;
			gpt_pre_q <= '0;
		end else if (cmd_clear || gpt_exp) begin
			gpt_run_q <= 1'b0;
		end else if (gpt_tick) begin
			gpt_pre_q <= '0;
			gpt_cnt_q <= gpt_cnt_q - GPT_W'(1);
		end else if (gpt_run_q && fc_go) begin
			gpt_pre_q <= gpt_pre_q + PRE_W'(1);
		end
	end

	// wake-up timer counts rc clock edges and ignores clear
	assign wut_exp = wut_run_q && rc_tick && wut_cnt_q <= WUT_W'(1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wut_run_q <= 1'b0;
			wut_cnt_q <= '0;
		end else if (cmd_wut && !ctrl_q[CTL_WUMODE]) begin
			wut_run_q <= 1'b1;
			wut_cnt_q <= wut_val_q;
		end else if (wut_exp) begin
			wut_run_q <= 1'b0;
		end else if (wut_run_q && rc_tick) begin
			wut_cnt_q <= wut_cnt_q - WUT_W'(1);
		end
	end

	// sticky event flags; a new event beats a software clear
	always_comb begin
		flag_set          = '0;
		flag_set[FLG_NRE] = nrt_exp && !nrt_stop && !nrt_start;
		flag_set[FLG_GPT] = gpt_exp && !gpt_start;
		flag_set[FLG_OSC] = osc_sync_q[1] && !osc_sync_q[2] && ctrl_q[CTL_OSC_EN];
		flag_set[FLG_TXE] = tx_end;
		flag_set[FLG_WT]  = wut_exp;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// successive approximation converter, msb first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adc_busy_q <= 1'b0;
			adc_rel_q  <= 1'b0;
			adc_bit_q  <= 3'h7;
			adc_try_q  <= 8'h00;
			adc_res_q  <= 8'h00;
			adc_wait_q <= '0;
		end else if (cmd_adc && !adc_busy_q) begin
			adc_busy_q <= 1'b1;
			adc_rel_q  <= phase_meas;
			adc_bit_q  <= 3'h7;
			adc_try_q  <= ADC_MID;
			adc_wait_q <= '0;
		end else if (adc_busy_q) begin
			if (adc_wait_q != ($bits(adc_wait_q))'(ADC_SETTLE)) begin
				adc_wait_q <= adc_wait_q + 1'b1;
			end else begin
				adc_wait_q <= '0;
				// comparator high keeps the trial bit
				adc_try_q[adc_bit_q] <= adc_sync_q[1];
				if (adc_bit_q == 3'h0) begin
					adc_busy_q <= 1'b0;
					adc_res_q  <= {adc_try_q[7:1], adc_sync_q[1]};
				end else begin
					adc_try_q[adc_bit_q - 3'h1] <= 1'b1;
					adc_bit_q <= adc_bit_q - 3'h1;
				end
			end
		end
	end
	assign adc_dac      = adc_try_q;
	assign adc_relative = adc_busy_q ? adc_rel_q : 1'b0;
endmodule

// file: verification/nfctm_properties.sv
// concurrent checks on the timer unit ports
`timescale 1ns/1ps
module nfctm_properties
	import nfctm_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        tx_end,
	input wire logic        rx_window,
	input wire logic        squelch_on,
	input wire logic        rx_watch,
	input wire logic        osc_enable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_resp_next: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_data_next: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_unmapped_errs: assert property ((rd_take and s_axi_araddr > OFS_ADC) |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_osc_en_follows: assert property (
		(wr_take and s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]) |->
		##2 osc_enable == $past(s_axi_wdata[0], 2))
		else $error("oscillator enable not taken");
	a_tx_end_masks: assert property (tx_end |-> ##[1:2] !rx_window)
		else $error("receive window open after transmit end");
	a_squelch_blocks: assert property (squelch_on |-> !rx_window)
		else $error("squelch with open window");
	a_watch_after_mask: assert property ($rose(rx_watch) |-> !squelch_on)
		else $error("watch began during mask");
endmodule

bind nfctm_top nfctm_properties u_props (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .tx_end, .rx_window, .squelch_on, .rx_watch, .osc_enable
);

// file: verification/nfctm_ctl_model.sv
// controller model issuing register cycles
`timescale 1ns/1ps
module nfctm_ctl_model (
	input  wire logic   aclk,
	output logic [7:0]  s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  wire logic   s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  wire logic   s_axi_wready,
	input  wire logic   s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic        s_axi_arvalid,
	input  wire logic   s_axi_arready,
	input  wire logic   s_axi_rvalid,
	output logic        s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// callers only reconfigure idle timers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
endmodule

// file: verification/test_nfctm_top.sv
// self-checking bench for the reader protocol timer unit
`timescale 1ns/1ps
module test_nfctm_top
	import nfctm_pkg::*;
;
	localparam logic [31:0] C = 32'h0000_0101;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, fc_en, tx_end, rx_sof, rx_eof, reply_busy, peer_field_on;
	logic        peer_field_off, osc_stable_pin, rc_clk_pin, adc_comp_pin, phase_meas;
	logic        osc_enable, rc_osc_enable, rx_window, squelch_on, rx_watch, adc_relative;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rc_div;
	logic [3:0]  s_axi_wstrb, ev;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, adc_dac, tgt;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [33:0] exp_q[$];
	int          err_count, total_checks, n;
	assign {peer_field_off, rx_eof, rx_sof, tx_end} = ev;
	nfctm_top u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fc_en, .tx_end, .rx_sof, .rx_eof,
		.reply_busy, .peer_field_on, .peer_field_off, .osc_stable_pin, .rc_clk_pin,
		.adc_comp_pin, .phase_meas, .osc_enable, .rc_osc_enable, .rx_window, .squelch_on,
		.rx_watch, .adc_dac, .adc_relative
	);
	nfctm_ctl_model u_mdl (
		.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
	);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// slow clock only while enabled; comparator sees input half a step above tgt
	always @(posedge aclk) begin
		{rc_clk_pin, rc_div} <= rc_osc_enable ? {rc_clk_pin, rc_div} + 3'h1 : 3'h0;
		adc_comp_pin <= {adc_dac, 1'b0} < {tgt, 1'b1};
	end
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, e});
		u_mdl.rd(a);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic pl(input int b);
		ev <= 4'h1 << b;
		@(posedge aclk);
		ev <= 4'h0;
		@(posedge aclk);
	endtask
	task automatic clr;
		u_mdl.wr(OFS_FLAGS, 32'h0000_001f);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		test_done();
	end
	initial begin
		{aresetn, reply_busy, peer_field_on, osc_stable_pin, phase_meas, ev} = '0;
		{rc_clk_pin, rc_div, adc_comp_pin, tgt} = '0;
		fc_en = 1'b1;
		seed = 32'h0000_c1b7;
		cyc(12);
		aresetn <= 1'b1;
		cyc(1);
		rx(OFS_STATUS, 32'h0000_0040);
		rx(8'h24, 32'h0000_0000, RESP_SLVERR);
		u_mdl.wr(OFS_CTRL, C);
		osc_stable_pin <= 1'b1;
		cyc(6);
		rx(OFS_FLAGS, 32'h0000_0004);
		rx(OFS_STATUS, 32'h0000_0060);
		$display("reset test done");
		u_mdl.wr(OFS_MRT, 32'h0000_0001);
		u_mdl.wr(OFS_NRT, 32'h0000_0003);
		pl(0);
		rx(OFS_STATUS, 32'h0000_0023);
		cyc(250);
		rx(OFS_FLAGS, 32'h0000_000d);
		rx(OFS_STATUS, 32'h0000_0020);
		clr();
		pl(0);
		cyc(90);
		pl(1);
		cyc(250);
		rx(OFS_FLAGS, 32'h0000_0008);
		rx(OFS_STATUS, 32'h0000_0060);
		clr();
		$display("transmit test done");
		u_mdl.wr(OFS_NRT, 32'h0000_0001);
		for (int i = 0; i < 2; i++) begin
			n = i ? STEP_NRT_HI : STEP_NRT_LO;
			u_mdl.wr(OFS_CTRL, C | 32'(i) << CTL_NRT_STEP);
			u_mdl.wr(OFS_CMD, 32'h0000_0004);
			cyc(n / 2);
			u_mdl.wr(OFS_CMD, 32'h0000_0004);
			cyc(n - 16);
			rx(OFS_FLAGS, 32'h0000_0000);
			cyc(32);
			rx(OFS_FLAGS, 32'h0000_0001);
			clr();
		end
		for (int i = 0; i < 2; i++) begin
			reply_busy <= 1'(i);
			u_mdl.wr(OFS_CTRL, C | 32'(i) << CTL_NRT_EMV);
			u_mdl.wr(OFS_CMD, 32'h0000_0006);
			u_mdl.wr(OFS_CMD, 32'h0000_0001);
			cyc(100);
			rx(OFS_FLAGS, 32'(i));
			rx(OFS_STATUS, 32'h0000_0060);
			clr();
		end
		reply_busy <= 1'b0;
		cyc(100);
		rx(OFS_FLAGS, 32'h0000_0000);
		$display("no-response test done");
		u_mdl.wr(OFS_GPT, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			u_mdl.wr(OFS_CTRL, C | 32'(i) << CTL_GPT_TRIG | 32'(i == 3) << CTL_P2P);
			if (i == 0)
				u_mdl.wr(OFS_CMD, 32'h0000_0008);
			else
				pl(i);
			cyc(100);
			rx(OFS_FLAGS, 32'h0000_0002);
			clr();
		end
		$display("general timer test done");
		u_mdl.wr(OFS_WUT, 32'h0000_0002);
		for (int i = 0; i < 2; i++) begin
			u_mdl.wr(OFS_CTRL, C | 32'(i) << CTL_WUMODE);
			u_mdl.wr(OFS_CMD, 32'h0000_0010);
			cyc(60);
			rx(OFS_FLAGS, i ? 32'h0000_0000 : 32'h0000_0010);
			clr();
		end
		u_mdl.wr(OFS_MRT, 32'h0000_0001);
		u_mdl.wr(OFS_CTRL, C | 32'h0000_0040);
		u_mdl.wr(OFS_CMD, 32'h0000_0002);
		cyc(400);
		rx(OFS_STATUS, 32'h0000_0021);
		cyc(150);
		rx(OFS_STATUS, 32'h0000_00e0);
		u_mdl.wr(OFS_CMD, 32'h0000_0001);
		u_mdl.wr(OFS_CTRL, C | 32'h0000_0020);
		u_mdl.wr(OFS_CMD, 32'h0000_0004);
		rx(OFS_STATUS, 32'h0000_0060);
		pl(0);
		peer_field_on <= 1'b1;
		cyc(1);
		peer_field_on <= 1'b0;
		rx(OFS_STATUS, 32'h0000_0021);
		cyc(100);
		rx(OFS_FLAGS, 32'h0000_0008);
		clr();
		pl(0);
		cyc(250);
		rx(OFS_FLAGS, 32'h0000_0009);
		u_mdl.wr(OFS_CMD, 32'h0000_0002);
		clr();
		$display("wake-up and target test done");
		u_mdl.wr(OFS_CTRL, C);
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			tgt <= i ? 8'hff : seed[7:0];
			phase_meas <= 1'(i);
			u_mdl.wr(OFS_CMD, 32'h0000_0020);
			cyc(250);
			rx(OFS_ADC, {23'h00_0000, 1'(i), i ? 8'hff : seed[7:0]});
		end
		u_mdl.wr(OFS_CTRL, 32'h0000_0000);
		u_mdl.wr(OFS_CMD, 32'h0000_0008);
		cyc(100);
		rx(OFS_STATUS, 32'h0000_0044);
		$display("converter and clock test done");
		test_done();
	end
endmodule
